/* rtl/rsc_pkg.sv */
// package: constants and types for the run and major-state control block
package rsc_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [3:0] RSC_OFS_CMD  = 4'h0;
  localparam logic [3:0] RSC_OFS_CFG  = 4'h4;
  localparam logic [3:0] RSC_OFS_STAT = 4'h8;
  localparam logic [3:0] RSC_OFS_DISP = 4'hC;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RSC_CMD_START   = 0;
  localparam int RSC_CMD_CONT    = 1;
  localparam int RSC_CMD_STOP    = 2;
  localparam int RSC_CMD_MSTEP   = 3;
  localparam int RSC_CMD_ION_ON  = 4;
  localparam int RSC_CMD_ION_OFF = 5;
  localparam int RSC_CMD_DONE    = 6;
  localparam int RSC_CMD_USER    = 7;
  localparam int RSC_CFG_DISPMEM = 0;
  localparam int RSC_CFG_SHIFT   = 1;
  localparam int RSC_CFG_SERIAL  = 2;
  localparam int RSC_CFG_KEY     = 3;
  localparam int RSC_CFG_DCH     = 4;
  localparam int RSC_CFG_CONSOLE_KEY_MODE_FLAG    = 5;
  localparam int RSC_DISC_CONSOLE_KEY_MODE_FLAG   = 0;
  localparam int RSC_DISC_DCH    = 1;
  localparam int RSC_DISC_RUN    = 2;
  localparam int RSC_DISC_KEY    = 3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RSC_MS_NONE, RSC_MS_FETCH, RSC_MS_DEFER, RSC_MS_EXEC} rsc_major_e;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } rsc_avs_req_s;

  typedef struct packed {
    logic supply_good;
    logic mem_supply_good;
    logic console_reset_n;
    logic halt_n;
  } rsc_pwr_s;

  typedef struct packed {
    logic run;
    logic ion;
    logic fetch;
    logic defer;
    logic execute;
  } rsc_ind_s;

  typedef struct packed {
    logic [3:0]  sync_m;
    logic [3:0]  sync_s;
    logic        init_lvl;
    logic        reset_pulse;
    logic        preset_pulse;
    logic [3:0]  disc;
    rsc_major_e  major;
    logic        fetch;
    logic        defer;
    logic        execute;
    logic        ion;
    logic        supervisor;
    logic        go_pend;
    logic        stop_pend;
    logic        step_pend;
    logic        step_active;
    logic        cycle_go;
    logic [5:0]  cfg;
    logic        waitreq;
    logic [31:0] readdata;
    logic [15:0] data_disp;
    logic [14:0] addr_disp;
  } rsc_state_s;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [5:0] RSC_CFG_RST = 6'h00;
  localparam rsc_state_s RSC_ST_RST = '{
    sync_m: 4'h0, sync_s: 4'h0, init_lvl: 1'b0, reset_pulse: 1'b0,
    preset_pulse: 1'b0, disc: 4'h0, major: RSC_MS_FETCH, fetch: 1'b1,
    defer: 1'b0, execute: 1'b0, ion: 1'b0, supervisor: 1'b1,
    go_pend: 1'b0, stop_pend: 1'b0, step_pend: 1'b0, step_active: 1'b0,
    cycle_go: 1'b0, cfg: RSC_CFG_RST, waitreq: 1'b1, readdata: 32'h0000_0000,
    data_disp: 16'h0000, addr_disp: 15'h0000};

endpackage

/* rtl/rsc_run_state_control.sv */
// module: run flag, major-state flags, init pulses and discretes register
//
// Notes on behaviour
// (RULE1) each indicator output is high exactly while its flip-flop holds one
// (RULE2) run set means back-to-back processor cycles; run clear stops them
// (RULE3) keep an interrupt-enable flag and show it as an indicator
// (RULE4) fetch set: next processor cycle reads an instruction word
// (RULE5) defer set: next processor cycle reads an indirect address word
// (RULE6) execute set: next processor cycle accesses the operand in memory
// (RULE7) at most one of fetch, defer, execute is ever set
// (RULE8) finishing a console function leaves fetch set
// (RULE9) all clocked actions happen on the falling clock edge when enabled
// (RULE10) supply-good rising gives one pulse on both reset and preset
// (RULE11) console reset release, gated with supply-good, gives the same pulses
// (RULE12) run cannot be set while reset, supply, memory supply or halt is low
// (RULE13) while blocked, each phase-five and memory-clock coincidence loads run zero
// (RULE14) run sets only when unblocked and a console qualifier is true; in shift mode the code also sets it from the shift input without a qualifier
// (RULE15) each discretes stage is set or cleared independently from its own input
// (RULE16) discretes capture only on load strobe, otherwise they hold
// (RULE17) in shift mode discretes move one place right taking the serial input
// (RULE18) data display shows accumulator or memory word; address display the address
// (RULE19) reset clears device flags and interrupt enable, selects supervisor, stops
// (RULE20) reset pulse master-clears the discretes register including run
// (RULE21) rising edges found by comparing with the previous registered sample
module rsc_run_state_control (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire rsc_pkg::rsc_avs_req_s avs_req,
  output logic                      avs_waitrequest,
  output logic [31:0]               avs_readdata,
  input  wire rsc_pkg::rsc_pwr_s    pwr,
  input  wire logic                 phase_five_timing_pulse,
  input  wire logic                 mem_clock,
  input  wire logic                 cycle_end,
  input  wire logic                 next_defer,
  input  wire logic                 next_execute,
  input  wire logic [15:0]          acc_word,
  input  wire logic [15:0]          mem_word,
  input  wire logic [14:0]          pc_word,
  output rsc_pkg::rsc_ind_s         ind,
  output logic                      cycle_go,
  output logic                      reset_pulse,
  output logic                      preset_pulse,
  output logic                      io_clear,
  output logic                      supervisor,
  output logic [3:0]                discretes,
  output logic [15:0]               data_display,
  output logic [14:0]               addr_display
);
  import rsc_pkg::*;

  rsc_state_s st_q;
  rsc_state_s st_d;
  logic       sup_good;
  logic       mem_good;
  logic       con_rst_n;
  logic       halt_ok_n;
  logic       run_block;
  logic       strobe;
  logic       init_now;
  logic       run_in;
  logic       stop_now;
  logic       acc;
  logic       wr_cmd;
  logic       wr_cfg;
  logic [3:0] disc_in;
  logic [3:0] disc_nx;

  // ----------------------------------------------------------------
  // synchronised pin levels and run gating
  // ----------------------------------------------------------------
  // only the second sync stage is read
  assign sup_good  = st_q.sync_s[3];
  assign mem_good  = st_q.sync_s[2];
  assign con_rst_n = st_q.sync_s[1];
  assign halt_ok_n = st_q.sync_s[0];
  assign init_now  = con_rst_n & sup_good; // RULE11
  assign run_block = ~(con_rst_n & sup_good & mem_good & halt_ok_n); // RULE12
  assign strobe    = phase_five_timing_pulse & mem_clock; // RULE13
  assign stop_now  = st_q.stop_pend & st_q.fetch;
  // run input gate: unblocked and held or newly qualified
  assign run_in = ~run_block & ((st_q.disc[RSC_DISC_RUN] & ~stop_now) | st_q.go_pend); // RULE14

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign acc    = (avs_req.read | avs_req.write) & st_q.waitreq;
  assign wr_cmd = acc & avs_req.write & (avs_req.address == RSC_OFS_CMD);
  assign wr_cfg = acc & avs_req.write & (avs_req.address == RSC_OFS_CFG);

  // ----------------------------------------------------------------
  // discretes register stages
  // ----------------------------------------------------------------
  // stage inputs: run stage from the decision gating, the other three from cfg bits
  assign disc_in = {st_q.cfg[RSC_CFG_KEY], run_in, st_q.cfg[RSC_CFG_DCH], st_q.cfg[RSC_CFG_CONSOLE_KEY_MODE_FLAG]};

  // per-stage next value: clear, load, shift right or hold
  for (genvar i = 0; i < 4; i++) begin : g_disc
    logic shift_src;
    if (i == 3) begin : g_top
      assign shift_src = st_q.cfg[RSC_CFG_SERIAL];
    end else if (i == RSC_DISC_RUN) begin : g_run
      // a blocked run stage never picks up a one from shifting
      assign shift_src = st_q.disc[i+1] & ~run_block; // RULE12
    end else begin : g_low
      assign shift_src = st_q.disc[i+1];
    end
    assign disc_nx[i] = st_q.reset_pulse ? 1'b0 : // RULE20
                        strobe ? disc_in[i] : // RULE15 RULE16
                        st_q.cfg[RSC_CFG_SHIFT] ? shift_src : // RULE17
                        st_q.disc[i];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // two-stage pin synchroniser
    st_d.sync_m = {pwr.supply_good, pwr.mem_supply_good, pwr.console_reset_n, pwr.halt_n};
    st_d.sync_s = st_q.sync_m;
    // init pulse on rise of the gated level
    st_d.init_lvl     = init_now;
    st_d.reset_pulse  = init_now & ~st_q.init_lvl; // RULE10 RULE21
    st_d.preset_pulse = init_now & ~st_q.init_lvl; // RULE10 RULE11
    st_d.disc = disc_nx;
    // console qualifier held until the run stage loads
    st_d.go_pend   = (st_q.go_pend & ~strobe) | (wr_cmd & (avs_req.writedata[RSC_CMD_START] |
                     avs_req.writedata[RSC_CMD_CONT]));
    st_d.stop_pend = (st_q.stop_pend & ~(strobe & ~run_in)) | (wr_cmd & avs_req.writedata[RSC_CMD_STOP]);
    // memory step: one cycle while stopped
    st_d.step_pend = (st_q.step_pend & st_q.disc[RSC_DISC_RUN]) |
                     (wr_cmd & avs_req.writedata[RSC_CMD_MSTEP]);
    if (st_q.step_pend & ~st_q.disc[RSC_DISC_RUN]) begin
      st_d.step_active = 1'b1;
      st_d.step_pend   = wr_cmd & avs_req.writedata[RSC_CMD_MSTEP]; // a new request wins over the clear
    end else if (cycle_end) begin
      st_d.step_active = 1'b0;
    end
    st_d.cycle_go = disc_nx[RSC_DISC_RUN] | st_d.step_active; // RULE2
    // major state: console functions leave fetch, cycles advance it
    if (st_q.reset_pulse | (wr_cmd & (avs_req.writedata[RSC_CMD_DONE] |
        avs_req.writedata[RSC_CMD_START]))) begin
      st_d.major = RSC_MS_FETCH; // RULE8
    end else if (cycle_end & st_q.cycle_go) begin
      case ({next_defer, next_execute})
        2'b10, 2'b11: st_d.major = RSC_MS_DEFER; // RULE5
        2'b01:        st_d.major = RSC_MS_EXEC; // RULE6
        default:      st_d.major = RSC_MS_FETCH; // RULE4
      endcase
    end
    // one flag per state, never two at once
    case (st_d.major)
      RSC_MS_FETCH: {st_d.fetch, st_d.defer, st_d.execute} = 3'b100; // RULE7
      RSC_MS_DEFER: {st_d.fetch, st_d.defer, st_d.execute} = 3'b010;
      RSC_MS_EXEC:  {st_d.fetch, st_d.defer, st_d.execute} = 3'b001;
      default:      {st_d.fetch, st_d.defer, st_d.execute} = 3'b000;
    endcase
    // interrupt enable and mode
    if (wr_cmd & avs_req.writedata[RSC_CMD_ION_OFF]) begin
      st_d.ion = 1'b0;
    end
    if (wr_cmd & avs_req.writedata[RSC_CMD_ION_ON]) begin
      st_d.ion = 1'b1; // RULE3
    end
    if (wr_cmd & avs_req.writedata[RSC_CMD_USER]) begin
      st_d.supervisor = 1'b0;
    end
    if (st_q.reset_pulse) begin
      st_d.ion        = 1'b0; // RULE19
      st_d.supervisor = 1'b1; // RULE19
      st_d.stop_pend  = 1'b0;
      st_d.go_pend    = 1'b0;
    end
    if (wr_cfg) begin
      st_d.cfg = avs_req.writedata[5:0];
    end
    // console displays
    st_d.data_disp = st_q.cfg[RSC_CFG_DISPMEM] ? mem_word : acc_word; // RULE18
    st_d.addr_disp = pc_word; // RULE18
    // bus answer registered on the same falling edge that first sees the request
    st_d.waitreq = ~acc;
    if (acc & avs_req.read) begin
      case (avs_req.address)
        RSC_OFS_CFG:  st_d.readdata = {26'h0, st_q.cfg};
        RSC_OFS_STAT: st_d.readdata = {21'h0, st_q.cycle_go, st_q.disc, st_q.supervisor,
                                       st_q.execute, st_q.defer, st_q.fetch, st_q.ion,
                                       st_q.disc[RSC_DISC_RUN]};
        RSC_OFS_DISP: st_d.readdata = {1'b0, st_q.addr_disp, st_q.data_disp};
        default:      st_d.readdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register on the falling edge
  // ----------------------------------------------------------------
  always_ff @(negedge clock or negedge rst_n) begin // RULE9
    if (!rst_n) begin
      st_q <= RSC_ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // indicators straight from their flip-flops
  assign ind.run          = st_q.disc[RSC_DISC_RUN]; // RULE1
  assign ind.ion          = st_q.ion; // RULE1
  assign ind.fetch        = st_q.fetch;
  assign ind.defer        = st_q.defer;
  assign ind.execute      = st_q.execute;
  assign cycle_go         = st_q.cycle_go;
  assign reset_pulse      = st_q.reset_pulse;
  assign preset_pulse     = st_q.preset_pulse;
  assign io_clear         = st_q.reset_pulse; // RULE19
  assign supervisor       = st_q.supervisor;
  assign discretes        = st_q.disc;
  assign data_display     = st_q.data_disp;
  assign addr_display     = st_q.addr_disp;
  assign avs_waitrequest  = st_q.waitreq;
  assign avs_readdata     = st_q.readdata;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(negedge clock); endclocking
  default disable iff (!rst_n);

  a_state_one_hot: assert property ($onehot0({ind.fetch, ind.defer, ind.execute})) // RULE7
    else $error("more than one major-state flag set");
  a_block_clears_run: assert property ((strobe && run_block && !st_q.go_pend) |=> !ind.run) // RULE13
    else $error("run not cleared while blocked");
  a_run_set_cause: assert property ($rose(ind.run) |-> $past(!run_block && (strobe || st_q.cfg[RSC_CFG_SHIFT]))) // RULE14
    else $error("run set without unblocked strobe");
  a_block_no_set: assert property ((run_block && !ind.run) |=> !ind.run) // RULE12
    else $error("run set while blocked");
  a_init_both_pulses: assert property ($rose(init_now) |=> reset_pulse && preset_pulse ##1 !reset_pulse) // RULE10
    else $error("init pulse missing or too long");
  a_master_clear: assert property (reset_pulse |=> discretes == 4'h0) // RULE20
    else $error("discretes not cleared by reset");
  a_reset_flags: assert property (reset_pulse |=> !ind.ion && supervisor) // RULE19
    else $error("reset left interrupt enable or mode");
  a_disc_hold: assert property ((!strobe && !st_q.cfg[RSC_CFG_SHIFT] && !reset_pulse) |=> $stable(discretes)) // RULE16
    else $error("discretes changed without strobe");
  a_shift_right: assert property ((st_q.cfg[RSC_CFG_SHIFT] && !strobe && !reset_pulse) |=> // RULE17
    discretes == {$past(st_q.cfg[RSC_CFG_SERIAL]), $past(discretes[3] && !run_block), $past(discretes[2:1])})
    else $error("shift did not move right");
  a_done_to_fetch: assert property ((wr_cmd && avs_req.writedata[RSC_CMD_DONE]) |=> ind.fetch) // RULE8
    else $error("console function did not leave fetch");
  a_defer_next: assert property ((cycle_end && cycle_go && next_defer && !wr_cmd && !reset_pulse) |=> // RULE5
    ind.defer)
    else $error("defer not entered");
  a_run_cycles: assert property (ind.run |-> cycle_go) // RULE2
    else $error("running without processor cycles");

  c_run_rise: cover property ($rose(ind.run));
  c_defer_entry: cover property ($rose(ind.defer));
  c_init_pulse: cover property (reset_pulse);
  c_shift_mode: cover property (st_q.cfg[RSC_CFG_SHIFT] && !strobe);

endmodule

/* testbench/rsc_console_model.sv */
// model: power supply status lines and operator console switches
module rsc_console_model (
  input  wire logic        clock,
  input  wire logic        power_on,
  input  wire logic        reset_sw,
  input  wire logic        halt_sw,
  output rsc_pkg::rsc_pwr_s pwr
);
  timeunit 1ns;
  timeprecision 1ns;
  import rsc_pkg::*;

  logic [3:0] up_q;

  // ----------------------------------------------------------------
  // supplies settle after power on, logic supply before memory supply
  // ----------------------------------------------------------------
  initial begin
    pwr  = '0;
    up_q = 4'h0;
  end

  // switch levels are inverted and registered each clock; supplies ramp with a count
  always @(posedge clock) begin
    if (!power_on) begin
      up_q <= 4'h0;
    end else if (up_q != 4'hF) begin
      up_q <= up_q + 4'h1;
    end
    pwr.supply_good     <= (up_q >= 4'h4);
    pwr.mem_supply_good <= (up_q >= 4'h8);
    pwr.console_reset_n <= !reset_sw; // pressed switch pulls the line low
    pwr.halt_n          <= !halt_sw;
  end
endmodule

/* testbench/rsc_run_state_control_bench.sv */
// bench: self-checking test of run, major-state and discretes control
module rsc_run_state_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import rsc_pkg::*;

  logic         clock, rst_n, p5, mclk, cend, ndef, nexe, pon, rsw, hsw;
  logic [15:0]  acc, mem, ddisp;
  logic [14:0]  pc, adisp;
  rsc_avs_req_s avs_req;
  rsc_pwr_s     pwr;
  rsc_ind_s     ind;
  logic         wreq, cgo, rpul, ppul, ioc, sup;
  logic [31:0]  rdata, q;
  logic [3:0]   disc;
  int           err_count, checked, np;

  rsc_run_state_control i_rsc_run_state_control (
    .clock                   (clock),
    .rst_n                   (rst_n),
    .avs_req                 (avs_req),
    .avs_waitrequest         (wreq),
    .avs_readdata            (rdata),
    .pwr                     (pwr),
    .phase_five_timing_pulse (p5),
    .mem_clock               (mclk),
    .cycle_end               (cend),
    .next_defer              (ndef),
    .next_execute            (nexe),
    .acc_word                (acc),
    .mem_word                (mem),
    .pc_word                 (pc),
    .ind                     (ind),
    .cycle_go                (cgo),
    .reset_pulse             (rpul),
    .preset_pulse            (ppul),
    .io_clear                (ioc),
    .supervisor              (sup),
    .discretes               (disc),
    .data_display            (ddisp),
    .addr_display            (adisp)
  );

  rsc_console_model i_rsc_console_model (
    .clock    (clock),
    .power_on (pon),
    .reset_sw (rsw),
    .halt_sw  (hsw),
    .pwr      (pwr)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // avalon master: hold request until waitrequest seen low at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_req <= '{address: a, read: !w, write: w, writedata: d};
    do begin
      @(posedge clock);
    end while (wreq !== 1'b0);
    q = rdata;
    avs_req.read  <= 1'b0;
    avs_req.write <= 1'b0;
    @(posedge clock);
  endtask

  task wt(input int n);
    repeat (n) @(posedge clock);
  endtask

  // one coincidence of phase five and memory clock
  task strobe;
    p5   <= 1'b1;
    mclk <= 1'b1;
    @(posedge clock);
    p5   <= 1'b0;
    mclk <= 1'b0;
    @(posedge clock);
  endtask

  // one cycle end with the given decode, then the expected fetch/defer/execute
  task cyc(input logic d, input logic e, input logic [2:0] x);
    cend <= 1'b1;
    ndef <= d;
    nexe <= e;
    @(posedge clock);
    cend <= 1'b0;
    @(posedge clock);
    chk("major", {ind.fetch, ind.defer, ind.execute}, x);
  endtask

  task count_pulses(input int n);
    np = 0;
    repeat (n) begin
      @(posedge clock);
      if (rpul === 1'b1) np++;
      chk("preset", ppul, rpul);
      chk("ioclr", ioc, rpul);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_init;
    chk("fetch", ind.fetch, 1'b1);
    chk("run", ind.run, 1'b0);
    pon <= 1'b1;
    count_pulses(30);
    chk("pulses", np, 1);
    chk("sup", sup, 1'b1);
    $display("init test done");
  endtask

  task t_regs;
    bus(0, RSC_OFS_CFG, 0);
    chk("cfg rst", q, {26'h0, RSC_CFG_RST});
    bus(1, RSC_OFS_CFG, 32'hFFFF_FF29);
    bus(0, RSC_OFS_CFG, 0);
    chk("cfg rw", q, 32'h0000_0029);
    bus(0, RSC_OFS_CMD, 0);
    chk("cmd rd", q, 32'h0000_0000);
    bus(0, 4'h2, 0);
    chk("unmapped", q, 32'h0000_0000);
    bus(1, RSC_OFS_CFG, 0);
    $display("register test done");
  endtask

  task t_run;
    strobe;
    chk("no qual", ind.run, 1'b0);
    bus(1, RSC_OFS_CMD, 32'h0000_0001);
    strobe;
    chk("run", ind.run, 1'b1);
    chk("cgo", cgo, 1'b1);
    bus(0, RSC_OFS_STAT, 0);
    chk("stat", q, 32'h0000_0525);
    hsw <= 1'b1;
    wt(4);
    strobe;
    chk("halt", ind.run, 1'b0);
    bus(1, RSC_OFS_CMD, 32'h0000_0001);
    strobe;
    chk("blocked", ind.run, 1'b0);
    hsw <= 1'b0;
    wt(4);
    bus(1, RSC_OFS_CMD, 32'h0000_0002);
    strobe;
    chk("cont", ind.run, 1'b1);
    $display("run test done");
  endtask

  task t_major;
    cyc(1'b1, 1'b0, 3'b010);
    cyc(1'b0, 1'b1, 3'b001);
    cyc(1'b0, 1'b0, 3'b100);
    cyc(1'b1, 1'b1, 3'b010);
    bus(1, RSC_OFS_CMD, 32'h0000_0040);
    chk("done", {ind.fetch, ind.defer, ind.execute}, 3'b100);
    bus(1, RSC_OFS_CMD, 32'h0000_0004);
    strobe;
    chk("stop", ind.run, 1'b0);
    chk("cgo", cgo, 1'b0);
    cyc(1'b1, 1'b0, 3'b100);
    bus(1, RSC_OFS_CMD, 32'h0000_0008);
    chk("step go", cgo, 1'b1);
    cyc(1'b1, 1'b0, 3'b010);
    chk("step end", cgo, 1'b0);
    $display("major state test done");
  endtask

  task t_ion;
    bus(1, RSC_OFS_CMD, 32'h0000_0010);
    chk("ion on", ind.ion, 1'b1);
    bus(1, RSC_OFS_CMD, 32'h0000_0030);
    chk("ion both", ind.ion, 1'b1);
    bus(1, RSC_OFS_CMD, 32'h0000_0020);
    chk("ion off", ind.ion, 1'b0);
    $display("interrupt enable test done");
  endtask

  task t_disc;
    bus(1, RSC_OFS_CFG, 32'h0000_0018);
    strobe;
    chk("disc", disc, 4'hA);
    bus(1, RSC_OFS_CFG, 32'h0000_0020);
    wt(2);
    chk("hold", disc, 4'hA);
    strobe;
    chk("reload", disc, 4'h1);
    bus(1, RSC_OFS_CFG, 32'h0000_0006);
    chk("shift", disc, 4'h8);
    wt(1);
    chk("shift2", disc, 4'hC);
    bus(1, RSC_OFS_CFG, 0);
    $display("discretes test done");
  endtask

  task t_crst;
    bus(1, RSC_OFS_CMD, 32'h0000_0080);
    chk("user", sup, 1'b0);
    bus(1, RSC_OFS_CMD, 32'h0000_0011);
    strobe;
    chk("run", ind.run, 1'b1);
    rsw <= 1'b1;
    wt(4);
    bus(1, RSC_OFS_CFG, 32'h0000_0008);
    strobe;
    chk("rst stop", ind.run, 1'b0);
    chk("key", disc, 4'h8);
    rsw <= 1'b0;
    count_pulses(12);
    chk("pulses", np, 1);
    chk("mclr", disc, 4'h0);
    chk("ion", ind.ion, 1'b0);
    chk("sup", sup, 1'b1);
    chk("fetch", ind.fetch, 1'b1);
    $display("console reset test done");
  endtask

  task t_disp;
    acc <= 16'hA5C3;
    mem <= 16'h3C5A;
    pc  <= 15'h1234;
    bus(1, RSC_OFS_CFG, 0);
    wt(2);
    chk("acc", ddisp, 16'hA5C3);
    chk("addr", adisp, 15'h1234);
    bus(1, RSC_OFS_CFG, 32'h0000_0001);
    wt(1);
    chk("mem", ddisp, 16'h3C5A);
    bus(0, RSC_OFS_DISP, 0);
    chk("disp reg", q, {1'b0, 15'h1234, 16'h3C5A});
    $display("display test done");
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    test_done;
  end

  initial begin
    {rst_n, p5, mclk, cend, ndef, nexe, pon, rsw, hsw} = '0;
    {acc, mem, pc} = '0;
    avs_req   = '0;
    err_count = 0;
    checked   = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_init;
    t_regs;
    t_run;
    t_major;
    t_ion;
    t_disc;
    t_crst;
    t_disp;
    test_done;
  end
endmodule
